/* File: src/wlsp_pkg.sv */
// shared constants and carrier types for the write latch and sector protect block
package wlsp_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_PROTECT       = 8'h36;
    localparam logic [7:0] OP_UNPROTECT     = 8'h39;
    localparam int         SECTOR_COUNT     = 32;
    localparam int         SECTOR_LSB       = 16;
    localparam int         SECTOR_BITS      = 5;
    localparam logic       FLAG_RESET       = 1'b1;
    localparam int         ADDR_BYTES       = 3;
    localparam logic [5:0] BITS_OPCODE      = 6'h08;
    localparam logic [5:0] BITS_FULL_ADDR   = 6'h20;
    localparam logic [5:0] BITS_SATURATE    = 6'h3F;

    typedef enum logic [1:0] {
        WLSP_CMD_NONE      = 2'h0,
        WLSP_CMD_WRITE_EN  = 2'h1,
        WLSP_CMD_PROTECT   = 2'h3,
        WLSP_CMD_WRITE_DIS = 2'h2
    } wlsp_cmd_t;

    // one finished frame as seen at chip select release
    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [5:0]  bits;
    } wlsp_frame_t;
endpackage

/* File: src/wlsp_core.sv */
// serial command logic for the write permit latch and per-sector protect flags
`timescale 1ns/100ps

// How it works
// - modifying commands need the latch set first
// - opcode 06h sets latch at release
// - short or misaligned enable/disable frames ignored
// - opcode 04h clears latch at release
// - one flag per 64KB sector, reset protected
// - flag 1 rejects program/erase, 0 accepts
// - 36h plus address protects sector, clears latch
// - 39h plus address unprotects sector, clears latch
// - short protect frame aborts, latch cleared
// - lock set ignores protect, clears latch
// - suspend makes protect opcodes fully ignored
module wlsp_core
    import wlsp_pkg::*;
#(
    parameter int NUM_SECTORS = SECTOR_COUNT
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    link_clk,
    input  wire logic                    cs_n,
    input  wire logic                    mosi,
    input  wire logic                    protect_flags_lock,
    input  wire logic                    suspend_active,
    input  wire logic [SECTOR_BITS-1:0]  check_sector,
    input  wire logic                    check_is_modify,
    output logic                         modify_allowed,
    output logic                         write_permit_latch,
    output logic [NUM_SECTORS-1:0]       sector_protect_flag
);

    // ------------------------------------------------------------------
    // link domain: shift in bits while framed
    // ------------------------------------------------------------------
    // field positions of the shift word, taken from the frame and opcode lengths;
    // the opcode sits on top, the address below it, whole bytes are 2**ALIGN_BITS
    localparam int SHIFT_W    = int'(BITS_FULL_ADDR);
    localparam int OPCODE_LSB = SHIFT_W - int'(BITS_OPCODE);
    localparam int ADDR_W     = OPCODE_LSB;
    localparam int ALIGN_BITS = $clog2(int'(BITS_OPCODE));

    logic [SHIFT_W-1:0] shift_r;
    logic [5:0]         count_r;
    wlsp_frame_t        frame_r;
    logic               done_tgl_r;
    logic               cs_seen_r;
    logic               open_clr;

    // frame-open flag, cleared while select is high: the link clock may stop
    // between frames, so no clock edge is there to restart the count
    assign open_clr = rst | cs_n;

    always_ff @(posedge link_clk or posedge open_clr) begin
        if (open_clr)
            cs_seen_r <= 1'b0;
        else
            cs_seen_r <= 1'b1;
    end

    // shift register msb first; first edge of a frame restarts the count,
    // past the address only the byte phase is kept so long frames stay aligned
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            shift_r <= '0;
            count_r <= '0;
        end else if (!cs_n) begin
            if (!cs_seen_r) begin
                shift_r <= {shift_r[SHIFT_W-2:0], mosi};
                count_r <= 6'h01;
            end else begin
                if (count_r < BITS_FULL_ADDR)
                    shift_r <= {shift_r[SHIFT_W-2:0], mosi};
                if (count_r >= BITS_FULL_ADDR)
                    count_r[ALIGN_BITS-1:0] <= count_r[ALIGN_BITS-1:0] + ALIGN_BITS'(1);
                else
                    count_r <= count_r + 6'h01;
            end
        end
    end

    // capture the frame on the rising edge of chip select; the link clock
    // may stop outside frames, so the release edge itself closes the frame
    always_ff @(posedge cs_n or posedge rst) begin
        if (rst) begin
            frame_r    <= '0;
            done_tgl_r <= 1'b0;
        end else begin
            frame_r.opcode <= (count_r >= BITS_FULL_ADDR) ? shift_r[SHIFT_W-1:OPCODE_LSB]
                            : (count_r >= BITS_OPCODE)
                              ? 8'(shift_r >> (count_r - BITS_OPCODE)) : 8'h00;
            frame_r.addr   <= shift_r[ADDR_W-1:0];
            frame_r.bits   <= count_r;
            done_tgl_r     <= ~done_tgl_r;
        end
    end

    // ------------------------------------------------------------------
    // crossing: toggle synchroniser, frame word is stable until next frame
    // ------------------------------------------------------------------
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic lock_s1_r;
    logic lock_s2_r;
    logic susp_s1_r;
    logic susp_s2_r;

    // two flops per input; third toggle flop only for edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tgl_s1_r  <= 1'b0;
            tgl_s2_r  <= 1'b0;
            tgl_s3_r  <= 1'b0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            susp_s1_r <= 1'b0;
            susp_s2_r <= 1'b0;
        end else begin
            tgl_s1_r  <= done_tgl_r;
            tgl_s2_r  <= tgl_s1_r;
            tgl_s3_r  <= tgl_s2_r;
            lock_s1_r <= protect_flags_lock;
            lock_s2_r <= lock_s1_r;
            susp_s1_r <= suspend_active;
            susp_s2_r <= susp_s1_r;
        end
    end

    logic frame_done;
    assign frame_done = tgl_s2_r ^ tgl_s3_r;

    // ------------------------------------------------------------------
    // command decode in the core domain
    // ------------------------------------------------------------------
    function automatic logic byte_aligned(input logic [5:0] bits);
        return bits[ALIGN_BITS-1:0] == '0;
    endfunction

    function automatic logic [SECTOR_BITS-1:0] sector_of(input logic [23:0] a);
        return a[SECTOR_LSB +: SECTOR_BITS];
    endfunction

    // class of a closed frame; both sector opcodes share one class because
    // they differ only in the value written, enable/disable need whole bytes
    function automatic wlsp_cmd_t decode_cmd(input wlsp_frame_t f);
        wlsp_cmd_t c;
        c = WLSP_CMD_NONE;
        if (f.bits >= BITS_OPCODE) begin
            if (f.opcode == OP_PROTECT || f.opcode == OP_UNPROTECT)
                c = WLSP_CMD_PROTECT;
            else if (f.opcode == OP_WRITE_ENABLE && byte_aligned(f.bits))
                c = WLSP_CMD_WRITE_EN;
            else if (f.opcode == OP_WRITE_DISABLE && byte_aligned(f.bits))
                c = WLSP_CMD_WRITE_DIS;
        end
        return c;
    endfunction

    logic       is_prot_op;
    logic       addr_ok;
    logic       op_ok;
    logic [SECTOR_BITS-1:0] tgt_sector;

    assign is_prot_op = (frame_r.opcode == OP_PROTECT) || (frame_r.opcode == OP_UNPROTECT);
    assign op_ok      = (frame_r.bits >= BITS_OPCODE) && byte_aligned(frame_r.bits);
    assign addr_ok    = (frame_r.bits >= BITS_FULL_ADDR) && byte_aligned(frame_r.bits);
    assign tgt_sector = sector_of(frame_r.addr);

    // frame class, only meaningful while frame_done is high
    wlsp_cmd_t frame_cmd;
    assign frame_cmd = decode_cmd(frame_r);

    logic latch_r;
    logic latch_nxt;

    // latch next value, evaluated only when a frame closes
    always_comb begin
        latch_nxt = latch_r;
        if (frame_done) begin
            case (frame_cmd)
                WLSP_CMD_WRITE_EN:  latch_nxt = 1'b1;
                WLSP_CMD_WRITE_DIS: latch_nxt = 1'b0;
                WLSP_CMD_PROTECT: begin
                    if (!susp_s2_r)
                        latch_nxt = 1'b0;
                end
                default: latch_nxt = latch_r;
            endcase
        end
    end

    // latch register; suspend leaves it alone for protect opcodes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            latch_r <= 1'b0;
        else
            latch_r <= latch_nxt;
    end

    logic [NUM_SECTORS-1:0] flags_r;

    // flag update needs latch, full aligned address, no lock, no suspend
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_r <= {NUM_SECTORS{FLAG_RESET}};
        end else if (frame_done && is_prot_op && addr_ok && latch_r
                     && !lock_s2_r && !susp_s2_r) begin
            flags_r[tgt_sector] <= (frame_r.opcode == OP_PROTECT);
        end
    end

    assign write_permit_latch  = latch_r;
    assign sector_protect_flag = flags_r;

    // ------------------------------------------------------------------
    // program/erase gate
    // ------------------------------------------------------------------
    // needs latch and an unprotected sector; the array logic asks per access
    assign modify_allowed = check_is_modify && latch_r && !flags_r[check_sector];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_flag_needs_latch: assert property (@(posedge core_clk) disable iff (rst)
        $changed(flags_r) |-> $past(latch_r)) else $error("flag changed without latch");

    chk_enable_sets: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && op_ok && frame_r.opcode == OP_WRITE_ENABLE) |=> latch_r)
        else $error("write enable did not set latch");

    chk_disable_clears: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && op_ok && frame_r.opcode == OP_WRITE_DISABLE) |=> !latch_r)
        else $error("write disable did not clear latch");

    chk_latch_rise_cause: assert property (@(posedge core_clk) disable iff (rst)
        $rose(latch_r) |-> $past(frame_done && op_ok && frame_r.opcode == OP_WRITE_ENABLE))
        else $error("latch set without whole enable opcode");

    chk_prot_clears: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && is_prot_op && frame_r.bits >= BITS_OPCODE && !susp_s2_r)
        |=> !latch_r) else $error("protect frame left latch set");

    chk_lock_holds: assert property (@(posedge core_clk) disable iff (rst)
        (lock_s2_r && $past(lock_s2_r)) |-> $stable(flags_r))
        else $error("flags changed while locked");

    chk_suspend_holds: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && is_prot_op && susp_s2_r) |=> $stable(flags_r) && $stable(latch_r))
        else $error("protect opcode acted during suspend");

    chk_protect_sets: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && addr_ok && frame_r.opcode == OP_PROTECT && latch_r
         && !lock_s2_r && !susp_s2_r) |=> flags_r[$past(tgt_sector)])
        else $error("protect did not set flag");

    chk_unprotect_clears: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && addr_ok && frame_r.opcode == OP_UNPROTECT && latch_r
         && !lock_s2_r && !susp_s2_r) |=> !flags_r[$past(tgt_sector)])
        else $error("unprotect did not clear flag");

    chk_short_aborts: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && is_prot_op && !addr_ok) |=> $stable(flags_r))
        else $error("short protect frame changed a flag");

    chk_gate_flag: assert property (@(posedge core_clk) disable iff (rst)
        flags_r[check_sector] |-> !modify_allowed)
        else $error("modify allowed on protected sector");

    chk_latch_fall_cause: assert property (@(posedge core_clk) disable iff (rst)
        $fell(latch_r) |-> $past(frame_done))
        else $error("latch cleared outside a closed frame");

    chk_flag_one_sector: assert property (@(posedge core_clk) disable iff (rst)
        $changed(flags_r) |-> $past(frame_done) && $onehot(flags_r ^ $past(flags_r)))
        else $error("flags changed outside one addressed sector");

    chk_short_frame_idle: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && frame_r.bits < BITS_OPCODE) |=> $stable(latch_r) && $stable(flags_r))
        else $error("frame shorter than an opcode had an effect");

    chk_abort_clears: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && is_prot_op && !addr_ok && frame_r.bits >= BITS_OPCODE && !susp_s2_r)
        |=> !latch_r) else $error("aborted protect frame left latch set");

    chk_gate_latch: assert property (@(posedge core_clk) disable iff (rst)
        !latch_r |-> !modify_allowed)
        else $error("modify allowed without latch");

    chk_done_pulse: assert property (@(posedge core_clk) disable iff (rst)
        frame_done |=> !frame_done)
        else $error("frame close seen twice");

    chk_enable_whole: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && frame_r.opcode == OP_WRITE_ENABLE && !op_ok) |=> $stable(latch_r))
        else $error("partial enable frame changed latch");

    chk_lock_clears: assert property (@(posedge core_clk) disable iff (rst)
        (frame_done && is_prot_op && lock_s2_r && frame_r.bits >= BITS_OPCODE && !susp_s2_r)
        |=> !latch_r && $stable(flags_r)) else $error("locked protect frame took effect");

endmodule

/* File: testbench/wlsp_host.sv */
// host serial controller model that frames commands for the block
`timescale 1ns/100ps
module wlsp_host (
    output logic link_clk,
    output logic cs_n,
    output logic mosi
);
    // link clock idles low and runs only inside a frame
    initial begin
        link_clk = 1'b0;
        cs_n     = 1'b1;
        mosi     = 1'b0;
    end
    // shift nbits of a left-aligned word msb first, then release select
    task automatic send(input logic [31:0] word, input int nbits);
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = (i < 32) ? word[31-i] : 1'b0; // bits past the word are zero
            #32 link_clk = 1'b1;
            #32 link_clk = 1'b0;
        end
        #32 cs_n = 1'b1;
        mosi = ~mosi; // released line must not keep a stale bit
    endtask
endmodule

/* File: testbench/write_latch_sector_protect_test.sv */
// self-checking bench for the write latch and sector protect block
`timescale 1ns/100ps
module write_latch_sector_protect_test;
    import wlsp_pkg::*;
    logic                   core_clk, rst, link_clk, cs_n, mosi, lock, suspend;
    logic                   check_is_modify, modify_allowed, write_permit_latch;
    logic [SECTOR_BITS-1:0] check_sector;
    logic [31:0]            sector_protect_flag, exp_flags;
    int                     fails = 0;
    int                     n_tests = 0;

    wlsp_core u_wlsp_core (.core_clk(core_clk), .rst(rst), .link_clk(link_clk), .cs_n(cs_n),
        .mosi(mosi), .protect_flags_lock(lock), .suspend_active(suspend),
        .check_sector(check_sector), .check_is_modify(check_is_modify),
        .modify_allowed(modify_allowed), .write_permit_latch(write_permit_latch),
        .sector_protect_flag(sector_protect_flag));
    wlsp_host u_wlsp_host (.link_clk(link_clk), .cs_n(cs_n), .mosi(mosi));

    // -----------------------------------------------------------
    // shared helpers
    // -----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // 8 core cycles cover the 3-cycle answer and the gap between frames
    task automatic frame(input logic [31:0] word, input int nbits);
        u_wlsp_host.send(word, nbits);
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    task automatic chk_state(input logic latch);
        chk("latch", {31'h0, latch}, {31'h0, write_permit_latch});
        chk("flags", exp_flags, sector_protect_flag);
    endtask

    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_latch;
        frame(32'h06000000, 8);
        chk_state(1'b1);
        frame(32'h04000000, 8);
        chk_state(1'b0);
        frame(32'h06000000, 6);
        chk_state(1'b0);
        frame(32'h06000000, 40);
        chk_state(1'b1);
        frame(32'h04000000, 5);
        chk_state(1'b1);
        frame(32'h04000000, 12);
        chk_state(1'b1);
    endtask
    task automatic t_sector;
        frame(32'h04000000, 8);
        frame(32'h39051234, 32);
        chk_state(1'b0);
        frame(32'h06000000, 8);
        frame(32'h39051234, 32);
        exp_flags[5] = 1'b0;
        chk_state(1'b0);
        frame(32'h06000000, 8);
        frame(32'h391FABCD, 32);
        exp_flags[31] = 1'b0;
        chk_state(1'b0);
        frame(32'h06000000, 8);
        check_sector = 5'h05;
        check_is_modify = 1'b1;
        #1 chk("allowed", 32'h1, {31'h0, modify_allowed});
        check_sector = 5'h06;
        #1 chk("allowed", 32'h0, {31'h0, modify_allowed});
        check_is_modify = 1'b0;
        frame(32'h3605FFFF, 32);
        exp_flags[5] = 1'b1;
        chk_state(1'b0);
    endtask
    // protect frames aimed at an unprotected sector, so a wrong apply shows
    task automatic t_abort;
        frame(32'h06000000, 8);
        frame(32'h361F0000, 24);
        chk_state(1'b0);
        frame(32'h06000000, 8);
        frame(32'h361F0000, 36);
        chk_state(1'b0);
    endtask
    task automatic t_lock;
        lock = 1'b1;
        frame(32'h06000000, 8);
        frame(32'h361F0000, 32);
        chk_state(1'b0);
        frame(32'h06000000, 8);
        frame(32'h39070000, 32);
        chk_state(1'b0);
        lock = 1'b0;
    endtask
    task automatic t_suspend;
        frame(32'h06000000, 8);
        suspend = 1'b1;
        frame(32'h361F0000, 32);
        chk_state(1'b1);
        frame(32'h39070000, 32);
        chk_state(1'b1);
        suspend = 1'b0;
    endtask
    // second reset in mid-run: flags back to protected, link restarts clean
    task automatic t_reset;
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        exp_flags = 32'hFFFFFFFF;
        repeat (2) @(posedge core_clk);
        #1;
        chk_state(1'b0);
        frame(32'h06000000, 8);
        chk_state(1'b1);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // reset, then the scenarios in order
    initial begin
        rst = 1'b1;
        lock = 1'b0;
        suspend = 1'b0;
        check_sector = 5'h00;
        check_is_modify = 1'b1;
        exp_flags = 32'hFFFFFFFF;
        repeat (10) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk_state(1'b0);
        chk("allowed", 32'h0, {31'h0, modify_allowed});
        check_is_modify = 1'b0;
        t_latch();
        t_sector();
        t_abort();
        t_lock();
        t_suspend();
        t_reset();
        results();
    end
    // 26 frames of under 3 us each; a hang gets cut well after that
    initial begin
        #300000;
        fails++;
        results();
    end
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
endmodule
